// ==== core/dsm_pkg.sv ====
// Package of constants and types for the drive state machine
package dsm_pkg;

   typedef enum logic [7:0] {
      DSM_INIT    = 8'h01,
      DSM_SOD     = 8'h02,
      DSM_RTSO    = 8'h04,
      DSM_SWON    = 8'h08,
      DSM_OPEN    = 8'h10,
      DSM_QSTOP   = 8'h20,
      DSM_FREACT  = 8'h40,
      DSM_FAULT   = 8'h80
   } dsm_state_t;

   // Register byte offsets
   localparam logic [7:0] DSM_OFF_CTRL    = 8'h00;
   localparam logic [7:0] DSM_OFF_STATUS  = 8'h04;
   localparam logic [7:0] DSM_OFF_QSOPT   = 8'h08;
   localparam logic [7:0] DSM_OFF_COMMAND = 8'h0C;
   localparam logic [7:0] DSM_OFF_EVENT   = 8'h10;
   localparam logic [7:0] DSM_OFF_PARAM   = 8'h14;

   // Control word commands
   localparam logic [15:0] DSM_CW_DISABLE  = 16'h0000;
   localparam logic [15:0] DSM_CW_QSTOP    = 16'h0002;
   localparam logic [15:0] DSM_CW_SHUTDOWN = 16'h0006;
   localparam logic [15:0] DSM_CW_SWON     = 16'h0007;
   localparam logic [15:0] DSM_CW_ENABLE   = 16'h000F;
   localparam int          DSM_CW_RESET_BIT = 7;
   localparam int          DSM_CW_READY_BIT = 0;
   localparam int          DSM_CW_POWER_BIT = 1;
   localparam int          DSM_CW_QSN_BIT   = 2;
   localparam int          DSM_CW_RUN_BIT   = 3;

   // Status word low field per state
   localparam logic [9:0] DSM_SW_INIT   = 10'h000;
   localparam logic [9:0] DSM_SW_SOD    = 10'h250;
   localparam logic [9:0] DSM_SW_RTSO   = 10'h231;
   localparam logic [9:0] DSM_SW_SWON   = 10'h233;
   localparam logic [9:0] DSM_SW_OPEN   = 10'h237;
   localparam logic [9:0] DSM_SW_QSTOP  = 10'h217;
   localparam logic [9:0] DSM_SW_FREACT = 10'h21F;
   localparam logic [9:0] DSM_SW_FAULT  = 10'h218;

   localparam logic [2:0] DSM_QSOPT_RESET = 3'h2;
   localparam logic [2:0] DSM_QSOPT_LAST_AUTO = 3'h3;
   localparam logic [2:0] DSM_QSOPT_FIRST_HOLD = 3'h5;

   // Event register bit positions
   localparam int DSM_EV_INIT_DONE = 0;
   localparam int DSM_EV_INIT_ERR  = 1;
   localparam int DSM_EV_FAILURE   = 2;
   localparam int DSM_EV_REACT_DONE = 3;
   localparam int DSM_EV_STOP_DONE = 4;

endpackage : dsm_pkg

// ==== core/dsm_drive_state_machine.sv ====
// Supervisory drive state machine with an AHB-Lite register slave
`timescale 1ns/100ps

module dsm_drive_state_machine (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        init_done,
   input  wire logic        init_error,
   input  wire logic        failure,
   input  wire logic        reaction_done,
   input  wire logic        stop_done,
   input  wire logic [5:0]  mode_status,
   input  wire logic        param_wr,
   input  wire logic        param_run_change,
   output logic             param_accept,
   output logic             motor_energize,
   output logic             motor_turn,
   output logic             drive_enable,
   output logic             quick_stop_run,
   output logic             fault_react_run,
   output dsm_pkg::dsm_state_t state
);
   import dsm_pkg::*;

   dsm_state_t  next_state;
   logic [15:0] ctrl_word;
   logic        ctrl_wr;
   logic        reset_bit_q;
   logic [2:0]  qs_option;
   logic [31:0] motion_cmd;
   logic        ap_valid;
   logic        dp_write;
   logic        dp_active;
   logic [7:0]  dp_addr;
   logic [9:0]  status_low;
   logic [15:0] status_word;
   logic        reset_edge;
   logic        qs_auto;
   logic        qs_hold;

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign ap_valid  = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_active <= 1'b0;
         dp_write  <= 1'b0;
         dp_addr   <= 8'h00;
      end else begin
         dp_active <= ap_valid;
         dp_write  <= ap_valid && hwrite;
         dp_addr   <= haddr[7:0];
      end
   end

   assign ctrl_wr = dp_write && (dp_addr == DSM_OFF_CTRL);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_word  <= 16'h0000;
         qs_option  <= DSM_QSOPT_RESET;
         motion_cmd <= 32'h0000_0000;
      end else if (dp_write) begin
         if (dp_addr == DSM_OFF_CTRL)
            ctrl_word <= hwdata[15:0];
         if (dp_addr == DSM_OFF_QSOPT)
            qs_option <= hwdata[2:0];
         if (dp_addr == DSM_OFF_COMMAND)
            motion_cmd <= hwdata;
      end
   end

   // Edge on the fault reset bit, taken from the previous control word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         reset_bit_q <= 1'b0;
      else
         reset_bit_q <= ctrl_word[DSM_CW_RESET_BIT];
   end

   assign reset_edge = ctrl_word[DSM_CW_RESET_BIT] && !reset_bit_q;
   assign qs_auto = qs_option <= DSM_QSOPT_LAST_AUTO;
   assign qs_hold = qs_option >= DSM_QSOPT_FIRST_HOLD;

   // Commands compare the whole word; bit 7 high therefore blocks them
   always_comb begin
      next_state = state;
      unique case (state)
         DSM_INIT: begin
            if (init_error)
               next_state = DSM_FREACT;
            else if (init_done)
               next_state = DSM_SOD;
         end
         DSM_SOD: begin
            if (ctrl_word == DSM_CW_SHUTDOWN)
               next_state = DSM_RTSO;
         end
         DSM_RTSO: begin
            if (ctrl_word == DSM_CW_SWON)
               next_state = DSM_SWON;
            else if (ctrl_word == DSM_CW_DISABLE)
               next_state = DSM_SOD;
         end
         DSM_SWON: begin
            if (ctrl_word == DSM_CW_ENABLE)
               next_state = DSM_OPEN;
            else if (ctrl_word == DSM_CW_SHUTDOWN)
               next_state = DSM_RTSO;
            else if (ctrl_word == DSM_CW_DISABLE)
               next_state = DSM_SOD;
         end
         DSM_OPEN: begin
            if (ctrl_word == DSM_CW_SWON)
               next_state = DSM_SWON;
            else if (ctrl_word == DSM_CW_SHUTDOWN)
               next_state = DSM_RTSO;
            else if (ctrl_word == DSM_CW_DISABLE)
               next_state = DSM_SOD;
            else if (ctrl_word == DSM_CW_QSTOP)
               next_state = DSM_QSTOP;
         end
         DSM_QSTOP: begin
            if (stop_done && qs_auto)
               next_state = DSM_SOD;
            else if (qs_hold && stop_done && ctrl_word == DSM_CW_ENABLE)
               next_state = DSM_OPEN;
         end
         DSM_FREACT: begin
            if (reaction_done)
               next_state = DSM_FAULT;
         end
         DSM_FAULT: begin
            if (reset_edge)
               next_state = DSM_SOD;
         end
         default: next_state = DSM_INIT;
      endcase
      if (failure && state != DSM_FAULT && state != DSM_FREACT)
         next_state = DSM_FREACT;
   end

   // Stopping is reported complete only once; hold it while in quick stop
   logic stop_seen;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         stop_seen <= 1'b0;
      else if (state != DSM_QSTOP)
         stop_seen <= 1'b0;
      else if (stop_done)
         stop_seen <= 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state <= DSM_INIT;
      else if (state == DSM_QSTOP && stop_seen && qs_hold
               && ctrl_word == DSM_CW_ENABLE
               && !(failure))
         state <= DSM_OPEN;
      else
         state <= next_state;
   end

   always_comb begin
      unique case (state)
         DSM_INIT:   status_low = DSM_SW_INIT;
         DSM_SOD:    status_low = DSM_SW_SOD;
         DSM_RTSO:   status_low = DSM_SW_RTSO;
         DSM_SWON:   status_low = DSM_SW_SWON;
         DSM_OPEN:   status_low = DSM_SW_OPEN;
         DSM_QSTOP:  status_low = DSM_SW_QSTOP;
         DSM_FREACT: status_low = DSM_SW_FREACT;
         DSM_FAULT:  status_low = DSM_SW_FAULT;
         default:    status_low = DSM_SW_INIT;
      endcase
   end

   // Bit 14 has no meaning and is forced low
   assign status_word = {mode_status[5], 1'b0, mode_status[3:0],
                         status_low};

   // Parameter write gate
   always_comb begin
      unique case (state)
         DSM_OPEN, DSM_QSTOP, DSM_FREACT:
            param_accept = param_wr && param_run_change;
         default:
            param_accept = param_wr && (state != DSM_INIT);
      endcase
   end

   // Drive outputs from flip-flops; fault keeps everything off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         motor_energize  <= 1'b0;
         motor_turn      <= 1'b0;
         drive_enable    <= 1'b0;
         quick_stop_run  <= 1'b0;
         fault_react_run <= 1'b0;
      end else begin
         motor_energize  <= next_state == DSM_OPEN;
         motor_turn      <= next_state == DSM_OPEN
                            && motion_cmd != 32'h0000_0000;
         drive_enable    <= next_state == DSM_OPEN
                            || next_state == DSM_QSTOP;
         quick_stop_run  <= next_state == DSM_QSTOP;
         fault_react_run <= next_state == DSM_FREACT;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ap_valid && !hwrite) begin
         unique case (haddr[7:0])
            DSM_OFF_CTRL:    hrdata <= {16'h0000, ctrl_word};
            DSM_OFF_STATUS:  hrdata <= {16'h0000, status_word};
            DSM_OFF_QSOPT:   hrdata <= {29'h0, qs_option};
            DSM_OFF_COMMAND: hrdata <= motion_cmd;
            DSM_OFF_EVENT:   hrdata <= {24'h0, state};
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
   end

   a_reset_init: assert property (@(posedge hclk)
      $rose(hresetn) |-> status_low == DSM_SW_INIT)
      else $error("not in init after reset");
   a_init_done: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_INIT && init_done && !init_error && !failure
      |=> state == DSM_SOD)
      else $error("init done ignored");
   a_sod_ready: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_SOD && ctrl_word == DSM_CW_SHUTDOWN && !failure
      |=> status_word[9:0] == DSM_SW_RTSO)
      else $error("shutdown not taken");
   a_rtso_swon: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_RTSO && ctrl_word == DSM_CW_SWON && !failure
      |=> state == DSM_SWON)
      else $error("switch on not taken");
   a_swon_enable: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_SWON && ctrl_word == DSM_CW_ENABLE && !failure
      |=> state == DSM_OPEN ##1 motor_energize)
      else $error("enable not taken");
   a_open_qstop: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_OPEN && ctrl_word == DSM_CW_QSTOP && !failure
      |=> status_word[9:0] == DSM_SW_QSTOP)
      else $error("quick stop not taken");
   a_failure_react: assert property (@(posedge hclk) disable iff (!hresetn)
      failure && state != DSM_FAULT |=> state == DSM_FREACT)
      else $error("failure not handled");
   a_fault_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_FAULT && !reset_edge && !failure
      |=> state == DSM_FAULT)
      else $error("fault left without reset edge");
   a_bit14_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      !status_word[14])
      else $error("status bit 14 set");
   a_param_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_OPEN && param_wr && !param_run_change
      |-> !param_accept)
      else $error("non run-change write accepted");

   // Transitions not covered above, with failure held off except from init, fault reaction and fault
   a_init_error: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_INIT && init_error
      |=> state == DSM_FREACT)
      else $error("init error ignored");
   a_rtso_disable: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_RTSO && ctrl_word == DSM_CW_DISABLE && !failure
      |=> state == DSM_SOD)
      else $error("disable from ready not taken");
   a_swon_back: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_SWON && ctrl_word == DSM_CW_SHUTDOWN && !failure
      |=> state == DSM_RTSO)
      else $error("shutdown from switched on not taken");
   a_open_swon: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_OPEN && ctrl_word == DSM_CW_SWON && !failure
      |=> state == DSM_SWON)
      else $error("disable operation not taken");
   a_open_ready: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_OPEN && ctrl_word == DSM_CW_SHUTDOWN && !failure
      |=> status_word[9:0] == DSM_SW_RTSO)
      else $error("shutdown from enabled not taken");
   a_open_disable: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == DSM_SWON || state == DSM_OPEN)
      && ctrl_word == DSM_CW_DISABLE && !failure
      |=> state == DSM_SOD)
      else $error("disable voltage not taken");
   a_qstop_auto: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_QSTOP && stop_done && qs_auto && !failure
      |=> state == DSM_SOD)
      else $error("quick stop did not fall back");
   a_qstop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_QSTOP && qs_hold && ctrl_word != DSM_CW_ENABLE
      && !failure |=> state == DSM_QSTOP)
      else $error("quick stop left without command");
   a_qstop_resume: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_QSTOP && stop_seen && qs_hold
      && ctrl_word == DSM_CW_ENABLE && !failure
      |=> state == DSM_OPEN)
      else $error("quick stop resume not taken");
   a_react_done: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_FREACT && reaction_done
      |=> status_word[9:0] == DSM_SW_FAULT)
      else $error("fault reaction did not complete");
   a_fault_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_FAULT && reset_edge
      |=> state == DSM_SOD)
      else $error("fault reset edge ignored");
   // A held reset bit must freeze the command driven states SOD, RTSO, SWON and OPEN
   a_bit7_block: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_word[DSM_CW_RESET_BIT] && !failure
      && (state == DSM_SOD || state == DSM_RTSO
          || state == DSM_SWON || state == DSM_OPEN)
      |=> $stable(state))
      else $error("command taken while reset bit held");
   a_fault_accept: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_FAULT && param_wr |-> param_accept)
      else $error("parameter write refused in fault");
   a_drive_off: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_FAULT
      |-> !drive_enable && !motor_energize && !motor_turn)
      else $error("drive active in fault");
   a_motor_turn: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_OPEN && next_state == DSM_OPEN
      && motion_cmd != 32'h0000_0000 |=> motor_turn)
      else $error("motor not turning with command");
   a_unmatched: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_SOD && ctrl_word != DSM_CW_SHUTDOWN && !failure
      |=> state == DSM_SOD)
      else $error("unmatched word changed state");
   a_ctrl_store: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_wr |=> ctrl_word == $past(hwdata[15:0]))
      else $error("control word not stored");
   a_open_pattern: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_OPEN
      |-> status_word[6:5] == 2'h1 && status_word[3:0] == 4'h7)
      else $error("enabled pattern wrong");
   a_fault_pattern: assert property (@(posedge hclk) disable iff (!hresetn)
      state == DSM_FAULT
      |-> !status_word[6] && status_word[3:0] == 4'h8)
      else $error("fault pattern wrong");
   a_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      dp_active |-> hreadyout && !hresp)
      else $error("data phase stalled or errored");

endmodule : dsm_drive_state_machine

// ==== testbench/dsm_bus_master.sv ====
// Bus master model standing in for the fieldbus controller
`timescale 1ns/100ps
module dsm_bus_master (
   input  wire logic        hclk,
   input  wire logic [31:0] hrdata,
   input  wire logic        hreadyout,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             rd_strobe,
   output logic [31:0]      rd_word,
   output logic             timed_out
);
   initial begin
      hsel      = 1'b0;
      haddr     = 32'h0;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = 3'b010;
      hwdata    = 32'h0;
      rd_strobe = 1'b0;
      rd_word   = 32'h0;
      timed_out = 1'b0;
   end

   // Single word transfer; control words are whole commands built from
   // the ready, power, quick stop and run bits, bit 7 for fault reset
   task automatic xfer(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
      int n;
      n = 0;
      hsel   <= 1'b1;
      haddr  <= {24'h0, addr};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      if (wr) begin
         hwdata <= data;
      end
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      // Released data shows the inverse so a stale value cannot pass
      hwdata    <= ~data;
      rd_word   <= hrdata;
      rd_strobe <= ~wr;
      timed_out <= (n >= 100);
      @(posedge hclk);
      rd_strobe <= 1'b0;
   endtask : xfer
endmodule : dsm_bus_master

// ==== testbench/tb.sv ====
// Self-checking testbench for the drive state machine
`timescale 1ns/100ps
module tb;
   import dsm_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd_word, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        init_done = 0, init_error = 0, failure = 0;
   logic        reaction_done = 0, stop_done = 0, param_wr = 0;
   logic        param_run_change = 0, param_accept, motor_energize;
   logic        motor_turn, drive_enable, quick_stop_run, fault_react_run;
   logic        rd_strobe, timed_out;
   logic [5:0]  mode_status = 6'h00;
   dsm_state_t  state;
   logic [15:0] exp_q[$], mask_q[$];
   int          miscompares = 0, cmp_count = 0;

   always #5 hclk = ~hclk;

   dsm_bus_master m (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .rd_strobe(rd_strobe),
      .rd_word(rd_word), .timed_out(timed_out));

   dsm_drive_state_machine uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .init_done(init_done),
      .init_error(init_error), .failure(failure),
      .reaction_done(reaction_done), .stop_done(stop_done),
      .mode_status(mode_status), .param_wr(param_wr),
      .param_run_change(param_run_change), .param_accept(param_accept),
      .motor_energize(motor_energize), .motor_turn(motor_turn),
      .drive_enable(drive_enable), .quick_stop_run(quick_stop_run),
      .fault_react_run(fault_react_run), .state(state));

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t output level %b", $time, got);
      end
   endtask : cmp_bit

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp,
                           input logic [15:0] mask);
      cmp_count++;
      if ((got & mask) !== (exp & mask)) begin
         miscompares++;
         $display("CHECK FAILED t=%0t read %h want %h", $time, got, exp);
      end
   endtask : cmp_word

   // Oldest note is matched against each read as it completes
   always @(posedge hclk) begin
      if (rd_strobe === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp_word(rd_word[15:0], 16'hFFFF, 16'h0000);
            miscompares++;
         end else begin
            cmp_word(rd_word[15:0], exp_q.pop_front(), mask_q.pop_front());
         end
      end
      if (timed_out === 1'b1) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic expect_st(input logic [9:0] sw, input dsm_state_t st);
      exp_q.push_back({6'h00, sw});
      mask_q.push_back(16'h03FF);
      m.xfer(1'b0, DSM_OFF_STATUS, 32'h0);
      exp_q.push_back({8'h00, st});
      mask_q.push_back(16'h00FF);
      m.xfer(1'b0, DSM_OFF_EVENT, 32'h0);
   endtask : expect_st

   task automatic go(input logic [15:0] cw, input logic [9:0] sw,
                     input dsm_state_t st);
      m.xfer(1'b1, DSM_OFF_CTRL, {16'h0000, cw});
      expect_st(sw, st);
   endtask : go

   task automatic to_open;
      go(DSM_CW_SHUTDOWN, DSM_SW_RTSO, DSM_RTSO);
      go(DSM_CW_SWON, DSM_SW_SWON, DSM_SWON);
      go(DSM_CW_ENABLE, DSM_SW_OPEN, DSM_OPEN);
   endtask : to_open

   // By reference so the level is read at the falling edge, not at the call
   task automatic settle_check(ref logic got, input logic exp);
      @(negedge hclk);
      cmp_bit(got, exp);
      @(posedge hclk);
   endtask : settle_check

   initial begin
      void'($urandom(32'h9aa08bfc));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      expect_st(DSM_SW_INIT, DSM_INIT);
      r = $urandom;
      mode_status <= r[5:0];
      init_done <= 1'b1;
      repeat (2) @(posedge hclk);
      expect_st(DSM_SW_SOD, DSM_SOD);
      to_open();
      exp_q.push_back({r[5], 1'b0, r[3:0], DSM_SW_OPEN});
      mask_q.push_back(16'hFFFF);
      m.xfer(1'b0, DSM_OFF_STATUS, 32'h0);
      m.xfer(1'b1, DSM_OFF_COMMAND, {16'h0, r[31:16] | 16'h0001});
      @(negedge hclk);
      cmp_bit(motor_energize, 1'b1);
      cmp_bit(hresp, 1'b0);
      settle_check(motor_turn, 1'b1);
      m.xfer(1'b1, DSM_OFF_COMMAND, 32'h0);
      settle_check(motor_turn, 1'b0);
      go(DSM_CW_SWON, DSM_SW_SWON, DSM_SWON);
      go(DSM_CW_DISABLE, DSM_SW_SOD, DSM_SOD);
      go(DSM_CW_ENABLE, DSM_SW_SOD, DSM_SOD);
      go(DSM_CW_SHUTDOWN, DSM_SW_RTSO, DSM_RTSO);
      go(DSM_CW_DISABLE, DSM_SW_SOD, DSM_SOD);
      to_open();
      go(DSM_CW_SHUTDOWN, DSM_SW_RTSO, DSM_RTSO);
      go(DSM_CW_SWON, DSM_SW_SWON, DSM_SWON);
      go(DSM_CW_SHUTDOWN, DSM_SW_RTSO, DSM_RTSO);
      $display("test transitions done");
      for (int o = 0; o < 8; o++) begin
         if (o == 4) continue;
         m.xfer(1'b1, DSM_OFF_QSOPT, 32'(o));
         to_open();
         go(DSM_CW_QSTOP, DSM_SW_QSTOP, DSM_QSTOP);
         settle_check(quick_stop_run, 1'b1);
         stop_done <= 1'b1;
         repeat (2) @(posedge hclk);
         stop_done <= 1'b0;
         if (o < 4) begin
            expect_st(DSM_SW_SOD, DSM_SOD);
         end else begin
            expect_st(DSM_SW_QSTOP, DSM_QSTOP);
            go(DSM_CW_ENABLE, DSM_SW_OPEN, DSM_OPEN);
            go(DSM_CW_DISABLE, DSM_SW_SOD, DSM_SOD);
         end
      end
      $display("test quick stop done");
      to_open();
      failure <= 1'b1;
      param_wr <= 1'b1;
      repeat (2) @(posedge hclk);
      expect_st(DSM_SW_FREACT, DSM_FREACT);
      settle_check(fault_react_run, 1'b1);
      settle_check(param_accept, 1'b0);
      param_run_change <= 1'b1;
      settle_check(param_accept, 1'b1);
      param_run_change <= 1'b0;
      failure <= 1'b0;
      reaction_done <= 1'b1;
      repeat (2) @(posedge hclk);
      expect_st(DSM_SW_FAULT, DSM_FAULT);
      @(negedge hclk);
      cmp_bit(param_accept, 1'b1);
      cmp_bit(drive_enable, 1'b0);
      settle_check(motor_energize, 1'b0);
      param_wr <= 1'b0;
      reaction_done <= 1'b0;
      go(DSM_CW_SHUTDOWN, DSM_SW_FAULT, DSM_FAULT);
      go(16'h0080, DSM_SW_SOD, DSM_SOD);
      go(16'h0086, DSM_SW_SOD, DSM_SOD);
      go(DSM_CW_SHUTDOWN, DSM_SW_RTSO, DSM_RTSO);
      $display("test fault done");
      hresetn <= 1'b0;
      init_done <= 1'b0;
      init_error <= 1'b1;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      expect_st(DSM_SW_FREACT, DSM_FREACT);
      $display("test init error done");
      complete_run();
   end
endmodule : tb
